// ---- rtl/dlio_pkg.sv ----
package dlio_pkg;
  localparam int NUM_IN  = 9;
  localparam int PNUM_W  = 11;
  localparam int NUM_SRC = 8;
  localparam int DLY_W   = 8;
  localparam int FLAG_N  = 2000;
  localparam int CLK_HZ  = 125_000_000;
  localparam int OFF_DELAY_S = 30;
  localparam longint OFF_DELAY_CYC = longint'(OFF_DELAY_S) * longint'(CLK_HZ);
  localparam int SEC_CYC = CLK_HZ;
  localparam logic [NUM_IN*PNUM_W-1:0] DEST_RST = '0;
  // Slot order: st1 a, st1 b, st2 a, st2 b, st3, st4, st5, relay
  localparam logic [NUM_SRC*PNUM_W-1:0] SRC_RST = {11'h3f1, 11'h3ee, 11'h3eb, 11'h3f5,
                                                   11'h000, 11'h3ef, 11'h000, 11'h06f};
  localparam logic [DLY_W-1:0] DLY_RST = 8'h00;
  typedef enum logic [1:0] {
    DLIO_ENA  = 2'b00,
    DLIO_WAIT = 2'b01,
    DLIO_OFF  = 2'b11
  } dlio_en_t;
endpackage

// ---- rtl/dlio_router.sv ----
`timescale 1ns/10ps
// Function
// - Inputs two to ten are sampled each cycle and shown as flags.
// - Drive works only while enable is high; enable flag shows it.
// - Firing pulses switch off thirty seconds after enable drops.
// - Losing enable while running gives coast stop and ramp reset.
// - Each input two to ten has a destination 0 to 1999, default zero.
// - A new destination takes effect only after a drive reset.
// - With normal logic on, inputs two to five give inch and run commands.
// - Each input two to ten may be inverted before routing.
// - Status one and two rises are delayed 0 to 255 seconds.
// - Status one and two falls are immediate.
// - Each status output follows a flag picked by a source number.
// - Status one and two OR two invertible sources, with output inversion.
// - Status three to five and relay follow one source, invertible.
// - All six status outputs are shown as single-bit flags.
// - The delay count read value (delay_view) freezes at a trip until drive reset.
// - Run commands latch while normal logic is on.
module dlio_router #(
  parameter logic [31:0] OFF_CYC = 32'(dlio_pkg::OFF_DELAY_CYC),
  parameter logic [26:0] SEC_CYC = 27'(dlio_pkg::SEC_CYC)
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic [8:0]  prog_input,
  input  wire logic        drive_enable,
  input  wire logic        drive_running,
  input  wire logic        drive_reset,
  input  wire logic        trip,
  input  wire logic        cfg_wr,
  input  wire logic [98:0] dest_cfg,
  input  wire logic [87:0] src_cfg,
  input  wire logic [15:0] delay_cfg,
  input  wire logic [8:0]  in_inv,
  input  wire logic [3:0]  src_inv,
  input  wire logic [5:0]  out_inv,
  input  wire logic        logic_disable,
  input  wire logic [1999:0] src_flags,
  output logic [8:0]  in_flag,
  output logic        enable_flag,
  output logic [8:0]  route_level,
  output logic [98:0] route_dest,
  output logic        inch_rev,
  output logic        inch_fwd,
  output logic        run_rev,
  output logic        run_fwd,
  output logic        firing_off,
  output logic        coast_stop,
  output logic        ramp_reset,
  output logic        status_out_one,
  output logic        status_out_two,
  output logic        status_out_three,
  output logic        status_out_four,
  output logic        status_out_five,
  output logic        status_out_relay,
  output logic [5:0]  status_flag,
  output logic [15:0] delay_view
);
  logic [8:0]  in_flag_q, route_lvl_q;
  logic        enable_flag_q;
  logic [98:0] dest_pend_q, dest_act_q;
  logic [87:0] src_sel_q;
  logic [15:0] dly_q, dly_view_q;
  logic        inch_rev_q, inch_fwd_q, run_rev_q, run_fwd_q;
  logic        firing_off_q, coast_q, ramp_q, freeze_q;
  logic [31:0] off_cnt_q;
  logic [7:0]  sel_q;
  logic [5:0]  stat_q;
  logic [1:0]  pre;
  logic [7:0]  dcnt_q [2];
  dlio_pkg::dlio_en_t en_st_q;

  assign in_flag    = in_flag_q;
  assign enable_flag = enable_flag_q;
  assign route_level = route_lvl_q;
  assign route_dest = dest_act_q;
  assign inch_rev   = inch_rev_q;
  assign inch_fwd   = inch_fwd_q;
  assign run_rev    = run_rev_q;
  assign run_fwd    = run_fwd_q;
  assign firing_off = firing_off_q;
  assign coast_stop = coast_q;
  assign ramp_reset = ramp_q;
  assign status_out_one   = stat_q[0];
  assign status_out_two   = stat_q[1];
  assign status_out_three = stat_q[2];
  assign status_out_four  = stat_q[3];
  assign status_out_five  = stat_q[4];
  assign status_out_relay = stat_q[5];
  assign status_flag = stat_q;
  assign delay_view  = dly_view_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      in_flag_q     <= '0;
      enable_flag_q <= 1'b0;
      route_lvl_q   <= '0;
    end else if (clk_en) begin
      in_flag_q     <= prog_input;
      enable_flag_q <= drive_enable;
      route_lvl_q   <= in_flag_q ^ in_inv;
    end
  end

  // Routing stays on the old table until reset so a half-edited setup never drives
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dest_pend_q <= dlio_pkg::DEST_RST;
      dest_act_q  <= dlio_pkg::DEST_RST;
      src_sel_q   <= dlio_pkg::SRC_RST;
      dly_q       <= {dlio_pkg::DLY_RST, dlio_pkg::DLY_RST};
    end else if (clk_en) begin
      if (cfg_wr) begin
        dest_pend_q <= dest_cfg;
        src_sel_q   <= src_cfg;
        dly_q       <= delay_cfg;
      end
      if (drive_reset) begin
        dest_act_q <= dest_pend_q;
      end
    end
  end

  // Fixed command map; run bits hold until stop, reset or mapping removed
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      inch_rev_q <= 1'b0;
      inch_fwd_q <= 1'b0;
      run_rev_q  <= 1'b0;
      run_fwd_q  <= 1'b0;
    end else if (clk_en) begin
      if (logic_disable || !enable_flag_q || drive_reset) begin
        inch_rev_q <= 1'b0;
        inch_fwd_q <= 1'b0;
        run_rev_q  <= 1'b0;
        run_fwd_q  <= 1'b0;
      end else begin
        inch_rev_q <= route_lvl_q[0];
        inch_fwd_q <= route_lvl_q[1];
        run_rev_q  <= run_rev_q | route_lvl_q[2];
        run_fwd_q  <= run_fwd_q | route_lvl_q[3];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      // Enable flag resets low; starting in wait avoids a false coast pulse
      en_st_q      <= dlio_pkg::DLIO_WAIT;
      off_cnt_q    <= '0;
      firing_off_q <= 1'b0;
      coast_q      <= 1'b0;
      ramp_q       <= 1'b0;
    end else if (clk_en) begin
      ramp_q <= 1'b0;
      case (en_st_q)
        dlio_pkg::DLIO_ENA: begin
          off_cnt_q <= '0;
          if (!enable_flag_q) begin
            en_st_q <= dlio_pkg::DLIO_WAIT;
            coast_q <= drive_running;
            ramp_q  <= drive_running;
          end
        end
        dlio_pkg::DLIO_WAIT: begin
          if (enable_flag_q) begin
            en_st_q <= dlio_pkg::DLIO_ENA;
            coast_q <= 1'b0;
          end else if (off_cnt_q >= OFF_CYC - 32'h1) begin
            en_st_q      <= dlio_pkg::DLIO_OFF;
            firing_off_q <= 1'b1;
          end else begin
            off_cnt_q <= off_cnt_q + 32'h1;
          end
        end
        dlio_pkg::DLIO_OFF: begin
          if (enable_flag_q) begin
            en_st_q      <= dlio_pkg::DLIO_ENA;
            firing_off_q <= 1'b0;
            coast_q      <= 1'b0;
          end
        end
        default: begin
          en_st_q <= dlio_pkg::DLIO_ENA;
        end
      endcase
    end
  end

  // Out-of-range source numbers read as an inactive flag
  for (genvar i = 0; i < 8; i++) begin : g_sel
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        sel_q[i] <= 1'b0;
      end else if (clk_en) begin
        sel_q[i] <= (src_sel_q[i*11 +: 11] < 11'(dlio_pkg::FLAG_N)) ?
                    src_flags[src_sel_q[i*11 +: 11]] : 1'b0;
      end
    end
  end

  assign pre[0] = ((sel_q[0] ^ src_inv[0]) | (sel_q[1] ^ src_inv[1])) ^ out_inv[0];
  assign pre[1] = ((sel_q[2] ^ src_inv[2]) | (sel_q[3] ^ src_inv[3])) ^ out_inv[1];

  // Own prescaler per output so the first second is never short
  for (genvar j = 0; j < 2; j++) begin : g_dly
    logic [26:0] pcnt_q;
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        pcnt_q    <= '0;
        dcnt_q[j] <= '0;
        stat_q[j] <= 1'b0;
      end else if (clk_en) begin
        if (!pre[j]) begin
          pcnt_q    <= '0;
          dcnt_q[j] <= '0;
          stat_q[j] <= 1'b0;
        end else if (dcnt_q[j] >= dly_q[j*8 +: 8]) begin
          stat_q[j] <= 1'b1;
        end else if (pcnt_q >= SEC_CYC - 27'h1) begin
          pcnt_q    <= '0;
          dcnt_q[j] <= dcnt_q[j] + 8'h1;
        end else begin
          pcnt_q <= pcnt_q + 27'h1;
        end
      end
    end
  end

  for (genvar k = 2; k < 6; k++) begin : g_single
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        stat_q[k] <= 1'b0;
      end else if (clk_en) begin
        stat_q[k] <= sel_q[k+2] ^ out_inv[k];
      end
    end
  end

  // Trip set wins over a same-cycle reset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      freeze_q   <= 1'b0;
      dly_view_q <= '0;
    end else if (clk_en) begin
      freeze_q <= trip | (freeze_q & ~drive_reset);
      if (!freeze_q && !trip) begin
        dly_view_q <= {dcnt_q[1], dcnt_q[0]};
      end
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_enable_lost;
    clk_en && en_st_q == dlio_pkg::DLIO_ENA && !enable_flag_q && drive_running;
  endsequence
  sequence s_coast;
    coast_q && ramp_q ##1 ((coast_q || $past(enable_flag_q)) && (!ramp_q || !$past(clk_en)));
  endsequence

  chk_input_flag: assert property (clk_en |=> in_flag_q == $past(prog_input))
    else $error("input flag not sampled");
  chk_enable_flag: assert property (clk_en |=> enable_flag_q == $past(drive_enable))
    else $error("enable flag wrong");
  chk_firing_off: assert property ($rose(firing_off_q) |-> $past(en_st_q) == dlio_pkg::DLIO_WAIT
                                   && $past(off_cnt_q) == OFF_CYC - 32'h1)
    else $error("firing off at wrong time");
  chk_coast_stop: assert property (s_enable_lost |=> s_coast)
    else $error("coast stop missing");
  chk_dest_hold: assert property (clk_en && !drive_reset |=> $stable(dest_act_q))
    else $error("routing changed without reset");
  chk_default_map: assert property (clk_en && !logic_disable && enable_flag_q && !drive_reset
                                    |=> inch_fwd_q == $past(route_lvl_q[1]))
    else $error("inch map wrong");
  chk_input_inv: assert property (clk_en |=> route_lvl_q == $past(in_flag_q ^ in_inv))
    else $error("inversion wrong");
  chk_rise_delay: assert property (clk_en && pre[0] && dcnt_q[0] < dly_q[7:0] && !stat_q[0]
                                   |=> !stat_q[0])
    else $error("status one rose early");
  chk_fall_fast: assert property (clk_en && !pre[1] |=> !stat_q[1])
    else $error("status two fall delayed");
  chk_run_latch: assert property (run_fwd_q && clk_en && !logic_disable && enable_flag_q
                                  && !drive_reset |=> run_fwd_q)
    else $error("run latch dropped");
  chk_freeze_hold: assert property (freeze_q && clk_en |=> $stable(dly_view_q))
    else $error("frozen value moved");
endmodule

// ---- bench/dlio_field.sv ----
`timescale 1ns/10ps
// Terminal side: switches feed the inputs, indicator loads sample status lines
module dlio_field (
  input  wire logic       sys_clk,
  input  wire logic [8:0] sw_in,
  input  wire logic       sw_en,
  input  wire logic [5:0] st_line,
  output logic      [8:0] term_in,
  output logic            term_en,
  output logic      [5:0] lamp_q
);
  // Switch contacts settle on the bench's falling-edge schedule
  assign term_in = sw_in;
  assign term_en = sw_en;
  always_ff @(posedge sys_clk) begin
    lamp_q <= st_line;
  end
endmodule

// ---- bench/dlio_router_tb_top.sv ----
`timescale 1ns/10ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin bad_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module dlio_router_tb_top;
  logic          sys_clk = 1'b0;
  logic          rst_n = 1'b0;
  logic [8:0]    sw_in = 9'h000;
  logic          sw_en = 1'b1;
  logic          ce = 1'b1;
  logic          run = 1'b0;
  logic          drst = 1'b0;
  logic          trip = 1'b0;
  logic          cfg_wr = 1'b0;
  logic          ldis = 1'b0;
  logic [98:0]   dest = '0;
  logic [87:0]   src = dlio_pkg::SRC_RST;
  logic [15:0]   dly = 16'h0000;
  logic [8:0]    in_inv = 9'h000;
  logic [3:0]    src_inv = 4'h0;
  logic [5:0]    out_inv = 6'h00;
  logic [1999:0] flg = '0;
  logic [8:0]    term_in, in_flag, rl;
  logic          term_en, en_flag, ir, ifw, rr, rf, foff, cst, rrst;
  logic [5:0]    st, sf, lamp;
  logic [98:0]   rdest;
  logic [15:0]   dv;
  int            bad_count = 0;
  int            cmp_count = 0;
  int            cyc = 0;

  initial begin
    forever #4 sys_clk = ~sys_clk;
  end

  dlio_field field (.sys_clk(sys_clk), .sw_in(sw_in), .sw_en(sw_en), .st_line(st),
    .term_in(term_in), .term_en(term_en), .lamp_q(lamp));

  // Short counts keep the off delay and seconds tick simulable
  dlio_router #(.OFF_CYC(32'd20), .SEC_CYC(27'd4)) uut (.sys_clk(sys_clk), .rst_n(rst_n),
    .clk_en(ce), .prog_input(term_in), .drive_enable(term_en), .drive_running(run),
    .drive_reset(drst), .trip(trip), .cfg_wr(cfg_wr), .dest_cfg(dest), .src_cfg(src),
    .delay_cfg(dly), .in_inv(in_inv), .src_inv(src_inv), .out_inv(out_inv),
    .logic_disable(ldis), .src_flags(flg), .in_flag(in_flag), .enable_flag(en_flag),
    .route_level(rl), .route_dest(rdest), .inch_rev(ir), .inch_fwd(ifw), .run_rev(rr),
    .run_fwd(rf), .firing_off(foff), .coast_stop(cst), .ramp_reset(rrst),
    .status_out_one(st[0]), .status_out_two(st[1]), .status_out_three(st[2]),
    .status_out_four(st[3]), .status_out_five(st[4]), .status_out_relay(st[5]),
    .status_flag(sf), .delay_view(dv));

  task automatic w(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic cfg();
    cfg_wr = 1'b1;
    w(1);
    cfg_wr = 1'b0;
  endtask

  task automatic t_status();
    w(3);
    `CHK(sf, 6'h00)
    flg[111] = 1'b1;
    flg[1007] = 1'b1;
    flg[1013] = 1'b1;
    flg[1003] = 1'b1;
    flg[1006] = 1'b1;
    flg[1009] = 1'b1;
    w(3);
    `CHK(st, 6'h3f)
    `CHK(sf, 6'h3f)
    `CHK(lamp, 6'h3f)
    out_inv = 6'h3c;
    w(3);
    `CHK(sf, 6'h03)
    flg = '0;
    out_inv = 6'h00;
    src_inv = 4'h5;
    w(3);
    `CHK(st, 6'h03)
    src_inv = 4'ha;
    w(3);
    `CHK(st, 6'h03)
    src_inv = 4'h0;
    w(3);
    `CHK(st, 6'h00)
    out_inv = 6'h03;
    w(3);
    `CHK(st, 6'h03)
    out_inv = 6'h00;
    src[4*11+:11] = 11'h005;
    cfg();
    flg[5] = 1'b1;
    w(3);
    `CHK(st, 6'h04)
    flg = '0;
  endtask

  task automatic t_inputs();
    in_inv = 9'h001;
    sw_in = 9'h10f;
    w(3);
    `CHK(in_flag, 9'h10f)
    `CHK(rl, 9'h10e)
    `CHK({ir, ifw, rr, rf}, 4'b0111)
    sw_in = 9'h000;
    w(3);
    `CHK({ir, ifw, rr, rf}, 4'b1011)
    ldis = 1'b1;
    w(3);
    `CHK({ir, rr, rf}, 3'b000)
    ldis = 1'b0;
    in_inv = 9'h000;
    w(3);
  endtask

  task automatic t_dest();
    dest[10:0] = 11'h7cf;
    dest[98:88] = 11'h3e8;
    cfg();
    w(4);
    `CHK(rdest, 99'h0)
    drst = 1'b1;
    w(1);
    drst = 1'b0;
    w(2);
    `CHK(rdest, dest)
  endtask

  // Two-second delay, four-cycle seconds: rise lands on the tenth edge
  task automatic t_delay();
    dly = 16'h0002;
    cfg();
    flg[111] = 1'b1;
    w(9);
    `CHK(st[0], 1'b0)
    w(1);
    `CHK(st[0], 1'b1)
    w(3);
    flg[111] = 1'b0;
    w(2);
    `CHK(st[0], 1'b0)
    flg[111] = 1'b1;
    w(6);
    trip = 1'b1;
    w(1);
    trip = 1'b0;
    `CHK(dv, 16'h0001)
    w(6);
    `CHK(dv, 16'h0001)
    drst = 1'b1;
    w(1);
    drst = 1'b0;
    flg = '0;
    w(1);
    `CHK(dv, 16'h0002)
    w(2);
  endtask

  task automatic t_enable();
    int k;
    k = 0;
    run = 1'b1;
    sw_en = 1'b0;
    for (int i = 1; i <= 25; i++) begin
      w(1);
      k += int'(rrst);
      if (i == 2) `CHK(en_flag, 1'b0)
      if (i == 10) `CHK(foff, 1'b0)
      if (i == 21) `CHK(foff, 1'b0)
      if (i == 22) `CHK(foff, 1'b1)
    end
    `CHK(foff, 1'b1)
    `CHK(cst, 1'b1)
    `CHK(k, 1)
    sw_en = 1'b1;
    w(3);
    `CHK({en_flag, foff, cst}, 3'b100)
    run = 1'b0;
    sw_en = 1'b0;
    w(2);
    `CHK({cst, rrst}, 2'b00)
    sw_en = 1'b1;
    w(3);
  endtask

  // Low enable must hold every register, inputs included
  task automatic t_clken();
    ce = 1'b0;
    sw_in = 9'h1a5;
    w(3);
    `CHK(in_flag, 9'h000)
    ce = 1'b1;
    w(1);
    `CHK(in_flag, 9'h1a5)
    sw_in = 9'h000;
    w(2);
  endtask

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Whole run is about 125 cycles; the ceiling leaves ample margin
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      results();
    end
  end

  initial begin
    w(8);
    rst_n = 1'b1;
    t_status();
    t_inputs();
    t_dest();
    t_delay();
    t_enable();
    t_clken();
    results();
  end
endmodule
